/* File: rtl/dcci_pkg.sv */
// dcci_pkg: shared constants, register map and carrier types of the
// six-channel transfer controller; assumes 16-bit data and word addresses.
package dcci_pkg;

  localparam int NCH = 6;
  localparam int DW  = 16;

  // global register word addresses
  localparam logic [7:0] A_PRIORITY_ENABLE = 8'h00;
  localparam logic [7:0] A_ELEM_STEP_A     = 8'h01;
  localparam logic [7:0] A_ELEM_STEP_B     = 8'h02;
  localparam logic [7:0] A_FRAME_STEP_A    = 8'h03;
  localparam logic [7:0] A_FRAME_STEP_B    = 8'h04;
  localparam logic [7:0] A_ENGINE_STATUS   = 8'h05;
  // per-channel block: base + channel * stride + offset
  localparam logic [7:0] A_CH_BASE         = 8'h10;
  localparam logic [7:0] A_CH_STRIDE       = 8'h10;
  localparam logic [3:0] O_SRC             = 4'h0;
  localparam logic [3:0] O_DST             = 4'h1;
  localparam logic [3:0] O_ELEM            = 4'h2;
  localparam logic [3:0] O_SYNC_FRAME      = 4'h3;
  localparam logic [3:0] O_MODE            = 4'h4;
  localparam logic [3:0] O_RLD_SRC         = 4'h5;
  localparam logic [3:0] O_RLD_DST         = 4'h6;
  localparam logic [3:0] O_RLD_COUNT       = 4'h7;
  localparam logic [3:0] O_RLD_FRAME       = 4'h8;

  // priority_enable_control fields
  localparam int PE_ENABLE_LSB = 0;
  localparam int PE_RELOAD_SET = 6;
  localparam int PE_ROUTE_LSB  = 8;

  // channel_mode_control fields
  localparam int MC_AUTO_REINIT = 15;
  localparam int MC_IRQ_ENABLE  = 14;
  localparam int MC_IRQ_MODE    = 13;
  localparam int MC_AUTOBUF     = 12;
  localparam int MC_SRC_ISEL    = 10;
  localparam int MC_SRC_MODE    = 8;
  localparam int MC_DST_ISEL    = 4;
  localparam int MC_DST_MODE    = 2;
  localparam int MC_DOUBLEWORD  = 0;

  // sync_and_frame_reg fields
  localparam int SF_SYNC_LSB  = 12;
  localparam int SF_FRAME_LSB = 0;

  // reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_FRAME = 8'h00;

  // address post-modification modes
  localparam logic [1:0] AM_HOLD  = 2'h0;
  localparam logic [1:0] AM_INC   = 2'h1;
  localparam logic [1:0] AM_DEC   = 2'h2;
  localparam logic [1:0] AM_INDEX = 2'h3;

  // sync_event_select codes
  localparam logic [3:0] SY_NONE     = 4'h0;
  localparam logic [3:0] SY_SER_LO   = 4'h1;
  localparam logic [3:0] SY_SER_HI   = 4'h6;
  localparam logic [3:0] SY_ALT_LO   = 4'h7;
  localparam logic [3:0] SY_ALT_HI   = 4'hc;
  localparam logic [3:0] SY_TIMER    = 4'hd;
  localparam logic [3:0] SY_EXT3     = 4'he;
  localparam logic [3:0] SY_RESERVED = 4'hf;

  // interrupt_route_select codes
  localparam logic [1:0] RT_SERIAL  = 2'h0;
  localparam logic [1:0] RT_CH23    = 2'h1;
  localparam logic [1:0] RT_CH0123  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11,
    ST_ADJ   = 2'b10
  } dcci_state_t;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
  } dcci_mem_req_t;

  typedef struct packed {
    logic [5:0] ser;
    logic [5:0] alt;
    logic       timer;
  } dcci_evt_t;

  // shared lines 6, 7, 10, 11 fed by the serial ports when not routed
  typedef struct packed {
    logic port2_rx_irq;
    logic port2_tx_irq;
    logic port1_rx_irq;
    logic port1_tx_irq;
  } dcci_ser_irq_t;

endpackage

/* File: rtl/dcci_evt_sel.sv */
// dcci_evt_sel: picks each channel's synchronisation event.
// serial and timer events are one-cycle pulses on clk_sys; the external
// interrupt is a pin and is synchronised here before use.
`timescale 1ns/10ps
module dcci_evt_sel
  import dcci_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // events
  input  wire dcci_evt_t       evt,
  input  wire logic            external_interrupt_3_n,
  // per-channel select, 4 bits each
  input  wire logic [4*NCH-1:0] sel,
  output logic     [NCH-1:0]   hit
);

  logic [2:0] ext_reg;
  logic [2:0] ext_next;
  logic       ext_fall;

  always_comb begin
    ext_next = {ext_reg[1:0], external_interrupt_3_n};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_reg <= 3'h7;
    end else begin
      ext_reg <= ext_next;
    end
  end

  // edge taken between the second and third stage only
  assign ext_fall = ext_reg[2] & ~ext_reg[1];

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic [3:0] s;
      assign s = sel[4*c +: 4];
      always_comb begin
        hit[c] = 1'b0;
        if (s >= SY_SER_LO && s <= SY_SER_HI) begin
          hit[c] = evt.ser[3'(s - SY_SER_LO)];
        end else if (s >= SY_ALT_LO && s <= SY_ALT_HI) begin
          hit[c] = evt.alt[3'(s - SY_ALT_LO)];
        end else if (s == SY_TIMER) begin
          hit[c] = evt.timer;
        end else if (s == SY_EXT3) begin
          hit[c] = ext_fall;
        end
      end
    end
  endgenerate

endmodule

/* File: rtl/dcci_ctl.sv */
// dcci_ctl: six-channel transfer controller with counting, indexing,
// interrupt modes and shared interrupt line routing.
// assumes a memory port answering a read in the cycle after the request.
//
// Summary of operation
// - 8-bit frame count, zero means one frame
// - frame count decrements at frame's last write
// - block end with reinit reloads frame count
// - 16-bit element count, decrements every element
// - all-ones element count gives 65536 elements
// - block end with reinit reloads element count
// - doubleword: two 16-bit transfers, one element
// - index selects choose step pair per address
// - element step adjusts non-final frame transfers
// - frame step adjusts final frame transfer
// - interrupt enable clear blocks all interrupts
// - autobuffer: full only, or half and full
// - multiframe: block end only, or each frame
// - 4-bit select picks synchronisation event
// - one interrupt per channel, 0-3 shared
// - route select steers shared lines 6,7,10,11
// - reload set: shared channel 0 or own
// - addresses hold, increment, decrement or index
`timescale 1ns/10ps
module dcci_ctl
  import dcci_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata_reg,
  // memory port
  output dcci_mem_req_t      mem_req_reg,
  input  wire logic [DW-1:0] mem_rdata,
  // synchronisation sources
  input  wire dcci_evt_t     evt,
  input  wire logic          external_interrupt_3_n,
  // interrupts
  input  wire dcci_ser_irq_t ser_irq,
  output logic [NCH-1:0]     chan_irq_reg,
  output logic [3:0]         shared_line_reg
);

  logic [DW-1:0]      src_reg   [NCH];
  logic [DW-1:0]      src_next  [NCH];
  logic [DW-1:0]      dst_reg   [NCH];
  logic [DW-1:0]      dst_next  [NCH];
  logic [DW-1:0]      elem_reg  [NCH];
  logic [DW-1:0]      elem_next [NCH];
  logic [DW-1:0]      estart_reg  [NCH];
  logic [DW-1:0]      estart_next [NCH];
  logic [DW-1:0]      sf_reg    [NCH];
  logic [DW-1:0]      sf_next   [NCH];
  logic [DW-1:0]      mode_reg  [NCH];
  logic [DW-1:0]      mode_next [NCH];
  logic [DW-1:0]      gsa_reg   [NCH];
  logic [DW-1:0]      gsa_next  [NCH];
  logic [DW-1:0]      gda_reg   [NCH];
  logic [DW-1:0]      gda_next  [NCH];
  logic [DW-1:0]      gcr_reg   [NCH];
  logic [DW-1:0]      gcr_next  [NCH];
  logic [7:0]         gfr_reg   [NCH];
  logic [7:0]         gfr_next  [NCH];
  logic [DW-1:0]      pec_reg, pec_next;
  logic [DW-1:0]      esa_reg, esa_next, esb_reg, esb_next;
  logic [DW-1:0]      fsa_reg, fsa_next, fsb_reg, fsb_next;
  logic [NCH-1:0]     pend_reg, pend_next;
  dcci_state_t        state_reg, state_next;
  logic [2:0]         ch_reg, ch_next;
  logic               half_reg, half_next;
  dcci_mem_req_t      mem_next;
  logic [DW-1:0]      rdata_next;
  logic [NCH-1:0]     irq_next;
  logic [3:0]         line_next;
  logic [NCH-1:0]     hit;
  logic [4*NCH-1:0]   sync_sel;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_sel
      assign sync_sel[4*g +: 4] = sf_reg[g][SF_SYNC_LSB +: 4];
    end
  endgenerate

  dcci_evt_sel u_evt (
    .clk_sys                (clk_sys),
    .rst_n                  (rst_n),
    .evt                    (evt),
    .external_interrupt_3_n (external_interrupt_3_n),
    .sel                    (sync_sel),
    .hit                    (hit)
  );

  // address adjustment amount for one pointer
  function automatic logic [DW-1:0] step_of(input logic [1:0] am, input logic isel,
                                            input logic last, input logic first_half,
                                            input logic [DW-1:0] ea, input logic [DW-1:0] eb,
                                            input logic [DW-1:0] fa, input logic [DW-1:0] fb);
    logic [DW-1:0] r;
    r = '0;
    case (am)
      AM_INC:   r = 16'h0001;
      AM_DEC:   r = 16'hffff;
      AM_INDEX: begin
        // step choice; low half of a doubleword steps by one
        if (first_half) begin
          r = 16'h0001;
        end else if (last) begin
          r = isel ? fb : fa;
        end else begin
          r = isel ? eb : ea;
        end
      end
      default:  r = '0;
    endcase
    return r;
  endfunction

  // round-robin pick of the next channel after the last served one
  function automatic logic [3:0] pick(input logic [2:0] last, input logic [NCH-1:0] rdy);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = NCH; i >= 1; i--) begin
      k = 3'((32'(last) + i) % NCH);
      if (rdy[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [2:0]    c;
    logic [2:0]    rs;
    logic [3:0]    off;
    logic [3:0]    pk;
    logic [NCH-1:0] rdy;
    logic [3:0]    sy;
    logic          last_el;
    logic          last_fr;
    logic          fh;
    logic [DW-1:0] m;
    c = ch_reg;
    rs = '0;
    off = '0;
    pk = '0;
    rdy = '0;
    sy = '0;
    last_el = 1'b0;
    last_fr = 1'b0;
    fh = 1'b0;
    m = '0;
    src_next = src_reg;
    dst_next = dst_reg;
    elem_next = elem_reg;
    estart_next = estart_reg;
    sf_next = sf_reg;
    mode_next = mode_reg;
    gsa_next = gsa_reg;
    gda_next = gda_reg;
    gcr_next = gcr_reg;
    gfr_next = gfr_reg;
    pec_next = pec_reg;
    esa_next = esa_reg;
    esb_next = esb_reg;
    fsa_next = fsa_reg;
    fsb_next = fsb_reg;
    state_next = state_reg;
    ch_next = ch_reg;
    half_next = half_reg;
    mem_next = '0;
    irq_next = '0;
    rdata_next = '0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        A_PRIORITY_ENABLE: pec_next = reg_wdata;
        A_ELEM_STEP_A:     esa_next = reg_wdata;
        A_ELEM_STEP_B:     esb_next = reg_wdata;
        A_FRAME_STEP_A:    fsa_next = reg_wdata;
        A_FRAME_STEP_B:    fsb_next = reg_wdata;
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (reg_addr[7:4] == 4'(i + 1)) begin
              case (reg_addr[3:0])
                O_SRC:        src_next[i] = reg_wdata;
                O_DST:        dst_next[i] = reg_wdata;
                O_ELEM: begin
                  elem_next[i] = reg_wdata;
                  estart_next[i] = reg_wdata;
                end
                O_SYNC_FRAME: sf_next[i] = reg_wdata;
                O_MODE:       mode_next[i] = reg_wdata;
                O_RLD_SRC:    gsa_next[i] = reg_wdata;
                O_RLD_DST:    gda_next[i] = reg_wdata;
                O_RLD_COUNT:  gcr_next[i] = reg_wdata;
                O_RLD_FRAME:  gfr_next[i] = reg_wdata[7:0];
                default:      ;
              endcase
            end
          end
        end
      endcase
    end

    // register reads, unmapped words read zero
    if (reg_rd) begin
      case (reg_addr)
        A_PRIORITY_ENABLE: rdata_next = pec_reg;
        A_ELEM_STEP_A:     rdata_next = esa_reg;
        A_ELEM_STEP_B:     rdata_next = esb_reg;
        A_FRAME_STEP_A:    rdata_next = fsa_reg;
        A_FRAME_STEP_B:    rdata_next = fsb_reg;
        A_ENGINE_STATUS:   rdata_next = {8'h00, pend_reg[NCH-1:0] != '0, half_reg,
                                         state_reg, 1'b0, ch_reg};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (reg_addr[7:4] == 4'(i + 1)) begin
              case (reg_addr[3:0])
                O_SRC:        rdata_next = src_reg[i];
                O_DST:        rdata_next = dst_reg[i];
                O_ELEM:       rdata_next = elem_reg[i];
                O_SYNC_FRAME: rdata_next = sf_reg[i];
                O_MODE:       rdata_next = mode_reg[i];
                O_RLD_SRC:    rdata_next = gsa_reg[i];
                O_RLD_DST:    rdata_next = gda_reg[i];
                O_RLD_COUNT:  rdata_next = gcr_reg[i];
                O_RLD_FRAME:  rdata_next = {8'h00, gfr_reg[i]};
                default:      rdata_next = '0;
              endcase
            end
          end
        end
      endcase
    end

    // channel readiness
    for (int i = 0; i < NCH; i++) begin
      sy = sf_reg[i][SF_SYNC_LSB +: 4];
      // reserved code never ready; none means free running
      rdy[i] = pec_reg[PE_ENABLE_LSB + i] && (sy != SY_RESERVED)
               && ((sy == SY_NONE) || pend_reg[i]);
    end
    pk = pick(ch_reg, rdy);

    m = mode_reg[c];
    last_el = (elem_reg[c] == '0);
    last_fr = (sf_reg[c][SF_FRAME_LSB +: 8] == RST_FRAME);
    fh = m[MC_DOUBLEWORD] && !half_reg;
    rs = pec_reg[PE_RELOAD_SET] ? c : 3'h0;

    case (state_reg)
      ST_IDLE: begin
        if (pk[3] && !(reg_wr && reg_addr == A_PRIORITY_ENABLE)) begin
          ch_next = pk[2:0];
          half_next = 1'b0;
          state_next = ST_READ;
          mem_next = '{req: 1'b1, we: 1'b0, addr: src_reg[pk[2:0]], wdata: '0};
        end
      end
      ST_READ: begin
        state_next = ST_WRITE;
      end
      ST_WRITE: begin
        mem_next = '{req: 1'b1, we: 1'b1, addr: dst_reg[c], wdata: mem_rdata};
        state_next = ST_ADJ;
      end
      ST_ADJ: begin
        src_next[c] = src_reg[c] + step_of(m[MC_SRC_MODE +: 2], m[MC_SRC_ISEL], last_el, fh,
                                           esa_reg, esb_reg, fsa_reg, fsb_reg);
        dst_next[c] = dst_reg[c] + step_of(m[MC_DST_MODE +: 2], m[MC_DST_ISEL], last_el, fh,
                                           esa_reg, esb_reg, fsa_reg, fsb_reg);
        state_next = ST_IDLE;
        if (fh) begin
          half_next = 1'b1;
          state_next = ST_READ;
          mem_next = '{req: 1'b1, we: 1'b0, addr: src_next[c], wdata: '0};
        end else if (!last_el) begin
          elem_next[c] = elem_reg[c] - 16'h0001;
          if (m[MC_AUTOBUF] && m[MC_IRQ_MODE] && m[MC_IRQ_ENABLE]
              && elem_next[c] == (estart_reg[c] >> 1)) begin
            irq_next[c] = 1'b1;
          end
        end else if (m[MC_AUTOBUF]) begin
          elem_next[c] = estart_reg[c];
          irq_next[c] = m[MC_IRQ_ENABLE];
        end else if (!last_fr) begin
          sf_next[c][SF_FRAME_LSB +: 8] = sf_reg[c][SF_FRAME_LSB +: 8] - 8'h01;
          elem_next[c] = estart_reg[c];
          irq_next[c] = m[MC_IRQ_ENABLE] && m[MC_IRQ_MODE];
        end else begin
          irq_next[c] = m[MC_IRQ_ENABLE];
          if (m[MC_AUTO_REINIT]) begin
            elem_next[c] = gcr_reg[rs];
            estart_next[c] = gcr_reg[rs];
            sf_next[c][SF_FRAME_LSB +: 8] = gfr_reg[rs];
            src_next[c] = gsa_reg[rs];
            dst_next[c] = gda_reg[rs];
          end else begin
            pec_next[PE_ENABLE_LSB + c] = 1'b0;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase

    // events set pending after the start clears it, so a clash keeps it
    pend_next = pend_reg;
    if (state_reg == ST_IDLE && pk[3] && state_next == ST_READ) begin
      pend_next[pk[2:0]] = 1'b0;
    end
    pend_next = pend_next | hit;

    case (pec_reg[PE_ROUTE_LSB +: 2])
      RT_CH23:   line_next = {ser_irq.port2_rx_irq, ser_irq.port2_tx_irq,
                              irq_next[2], irq_next[3]};
      RT_CH0123: line_next = {irq_next[0], irq_next[1], irq_next[2], irq_next[3]};
      default:   line_next = {ser_irq.port2_rx_irq, ser_irq.port2_tx_irq,
                              ser_irq.port1_rx_irq, ser_irq.port1_tx_irq};
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        src_reg[i] <= RST_WORD;
        dst_reg[i] <= RST_WORD;
        elem_reg[i] <= RST_WORD;
        estart_reg[i] <= RST_WORD;
        sf_reg[i] <= RST_WORD;
        mode_reg[i] <= RST_WORD;
        gsa_reg[i] <= RST_WORD;
        gda_reg[i] <= RST_WORD;
        gcr_reg[i] <= RST_WORD;
        gfr_reg[i] <= RST_FRAME;
      end
      pec_reg <= RST_WORD;
      esa_reg <= RST_WORD;
      esb_reg <= RST_WORD;
      fsa_reg <= RST_WORD;
      fsb_reg <= RST_WORD;
      pend_reg <= '0;
      state_reg <= ST_IDLE;
      ch_reg <= 3'h0;
      half_reg <= 1'b0;
      mem_req_reg <= '0;
      reg_rdata_reg <= RST_WORD;
      chan_irq_reg <= '0;
      shared_line_reg <= 4'h0;
    end else begin
      src_reg <= src_next;
      dst_reg <= dst_next;
      elem_reg <= elem_next;
      estart_reg <= estart_next;
      sf_reg <= sf_next;
      mode_reg <= mode_next;
      gsa_reg <= gsa_next;
      gda_reg <= gda_next;
      gcr_reg <= gcr_next;
      gfr_reg <= gfr_next;
      pec_reg <= pec_next;
      esa_reg <= esa_next;
      esb_reg <= esb_next;
      fsa_reg <= fsa_next;
      fsb_reg <= fsb_next;
      pend_reg <= pend_next;
      state_reg <= state_next;
      ch_reg <= ch_next;
      half_reg <= half_next;
      mem_req_reg <= mem_next;
      reg_rdata_reg <= rdata_next;
      chan_irq_reg <= irq_next;
      shared_line_reg <= line_next;
    end
  end

endmodule

/* File: verification/dcci_ctl_props.sv */
// dcci_ctl_props: port-level checks of the transfer controller.
// assumes it is bound onto dcci_ctl and sees only that module's ports.
`timescale 1ns/10ps
module dcci_ctl_props
  import dcci_pkg::*;
(
  // clock and reset
  input wire logic           clk_sys,
  input wire logic           rst_n,
  // register port
  input wire logic           reg_rd,
  input wire logic [DW-1:0]  reg_rdata_reg,
  // memory port
  input wire dcci_mem_req_t  mem_req_reg,
  input wire logic [DW-1:0]  mem_rdata,
  // interrupts
  input wire dcci_ser_irq_t  ser_irq,
  input wire logic [NCH-1:0] chan_irq_reg,
  input wire logic [3:0]     shared_line_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic       rd_q;
  logic       wr_q;
  logic [3:0] ch_map;
  assign rd_q   = mem_req_reg.req & ~mem_req_reg.we;
  assign wr_q   = mem_req_reg.req & mem_req_reg.we;
  // line order 6,7,10,11 against channels 0..3
  assign ch_map = {chan_irq_reg[0], chan_irq_reg[1], chan_irq_reg[2], chan_irq_reg[3]};

  sequence s_rd; rd_q; endsequence
  sequence s_wr_late; ##2 wr_q; endsequence

  property p_rd_quiet; !reg_rd |=> reg_rdata_reg == 16'h0000; endproperty
  property p_rd_wr; s_rd |-> s_wr_late; endproperty
  property p_wr_has_rd; wr_q |-> $past(rd_q, 2); endproperty
  property p_wr_data; wr_q |-> mem_req_reg.wdata == $past(mem_rdata); endproperty
  // a doubleword's second read may follow its first write at once
  property p_req_pulse; (rd_q |=> !mem_req_reg.req) and (wr_q |=> !wr_q); endproperty
  property p_irq_pulse; (chan_irq_reg != 6'h00) |=> (chan_irq_reg == 6'h00); endproperty
  property p_irq_src; (chan_irq_reg != 6'h00) |-> $past(wr_q); endproperty
  // a line may only show a serial source that was up a cycle before, or a channel interrupt up then or now
  property p_shared;
    (shared_line_reg & ~($past(ser_irq) | $past(ch_map) | ch_map)) == 4'h0;
  endproperty

  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer cycle");
  a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
  a_wr_has_rd: assert property (p_wr_has_rd) else $error("write without read");
  a_wr_data: assert property (p_wr_data) else $error("write data differs from read");
  a_req_pulse: assert property (p_req_pulse) else $error("memory request too long");
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
  a_irq_src: assert property (p_irq_src) else $error("interrupt without transfer");
  a_shared: assert property (p_shared) else $error("shared line without source");
endmodule

bind dcci_ctl dcci_ctl_props dcci_ctl_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
  .mem_req_reg(mem_req_reg), .mem_rdata(mem_rdata), .ser_irq(ser_irq),
  .chan_irq_reg(chan_irq_reg), .shared_line_reg(shared_line_reg));

/* File: verification/dcci_mem_model.sv */
// dcci_mem_model: word memory on the far side of the transfer port.
// assumes one request per cycle; answers reads next cycle, logs writes.
`timescale 1ns/10ps
module dcci_mem_model
  import dcci_pkg::*;
(
  // clock
  input wire logic          clk_sys,
  // memory port
  input wire dcci_mem_req_t mem_req,
  output logic [DW-1:0]     mem_rdata
);
  logic [DW-1:0] mem [0:255];
  logic [31:0]   wlog [$];

  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h5a00 | 16'(i);
    end
  end

  // outside the answer cycle data toggles, so a sample one cycle late never matches
  always @(posedge clk_sys) begin
    if (mem_req.req && !mem_req.we) begin
      mem_rdata <= mem[mem_req.addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req.req && mem_req.we) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
      wlog.push_back({mem_req.addr, mem_req.wdata});
    end
  end
endmodule

/* File: verification/tb_top.sv */
// tb_top: register-level bench for the transfer controller.
// assumes the memory model answers reads and logs every write.
`timescale 1ns/10ps
module tb_top
  import dcci_pkg::*;
;
  logic           clk_sys   = 1'b0;
  logic           rst_n     = 1'b0;
  logic [7:0]     reg_addr  = 8'h00;
  logic [DW-1:0]  reg_wdata = 16'h0000;
  logic           reg_wr    = 1'b0;
  logic           reg_rd    = 1'b0;
  logic [DW-1:0]  rd_data;
  logic [DW-1:0]  rdata;
  dcci_mem_req_t  mem_req;
  logic [DW-1:0]  mem_rdata;
  dcci_evt_t      evt       = '0;
  logic           ext3_n    = 1'b1;
  dcci_ser_irq_t  ser_irq   = '0;
  logic [NCH-1:0] chan_irq;
  logic [3:0]     lines;
  logic [DW-1:0]  a;
  logic [31:0]    w;
  int             n_fail    = 0;
  int             n_checks  = 0;
  int             n_irq     = 0;
  int             n_line    = 0;
  int             i0;
  int             l0;
  int             bp;

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_irq  <= n_irq + int'(chan_irq[0]);
    n_line <= n_line + int'(lines[3]);
  end

  dcci_ctl dcci_ctl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(rd_data), .mem_req_reg(mem_req),
    .mem_rdata(mem_rdata), .evt(evt), .external_interrupt_3_n(ext3_n),
    .ser_irq(ser_irq), .chan_irq_reg(chan_irq), .shared_line_reg(lines));
  dcci_mem_model dcci_mem_model_i (.clk_sys(clk_sys), .mem_req(mem_req), .mem_rdata(mem_rdata));

  task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] wl(int j);
    return (j < dcci_mem_model_i.wlog.size()) ? dcci_mem_model_i.wlog[j] : 32'hffffffff;
  endfunction

  function automatic logic [15:0] nw();
    return 16'(dcci_mem_model_i.wlog.size());
  endfunction

  task automatic wr(logic [7:0] ad, logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] ad);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rdata = rd_data;
  endtask

  task automatic wait_idle(int ch);
    for (int i = 0; i < 100; i++) begin
      rd(8'h00);
      if (rdata[ch] === 1'b0) begin
        repeat (3) @(posedge clk_sys);
        return;
      end
    end
    n_fail++;
    report_and_stop();
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h12);
    chk("elem_count", rdata, RST_WORD);
    rd(8'h13);
    chk("sync_frame", rdata, RST_WORD);
    rd(8'h00);
    chk("prio_enable", rdata, RST_WORD);
    rd(8'h0f);
    chk("unmapped", rdata, 16'h0000);
    wr(A_ELEM_STEP_A, 16'h0002);
    wr(A_ELEM_STEP_B, 16'h0003);
    wr(A_FRAME_STEP_A, 16'h0005);
    wr(A_FRAME_STEP_B, 16'h0007);
    // three elements, two frames; irq mode, enable, index set and route vary
    for (int k = 0; k < 3; k++) begin
      wr(8'h10, 16'h0020);
      wr(8'h11, 16'h0080);
      wr(8'h12, 16'h0002);
      wr(8'h13, 16'h0001);
      wr(8'h14, (k == 0) ? 16'h6304 : (k == 1) ? 16'h4704 : 16'h2304);
      dcci_mem_model_i.wlog.delete();
      i0 = n_irq;
      l0 = n_line;
      wr(8'h00, (k == 0) ? 16'h0201 : (k == 1) ? 16'h0101 : 16'h0001);
      wait_idle(0);
      a = 16'h0020;
      for (int j = 0; j < 6; j++) begin
        w = wl(j);
        chk("dst_addr", w[31:16], 16'h0080 + 16'(j));
        chk("data", w[15:0], 16'h5a00 | a);
        // last element of a frame steps by the frame index
        a = a + ((j % 3 == 2) ? ((k == 1) ? 16'h0007 : 16'h0005) : ((k == 1) ? 16'h0003 : 16'h0002));
      end
      chk("writes", nw(), 16'h0006);
      chk("irqs", 16'(n_irq - i0), (k == 0) ? 16'h0002 : (k == 1) ? 16'h0001 : 16'h0000);
      chk("line6", 16'(n_line - l0), (k == 0) ? 16'h0002 : 16'h0000);
      rd(8'h00);
      chk("enable_clr", rdata & 16'h003f, 16'h0000);
    end
    @(posedge clk_sys);
    ser_irq <= '1;
    repeat (2) @(posedge clk_sys);
    chk("lines_serial", 16'(lines), 16'h000f);
    wr(8'h00, 16'h0200);
    repeat (2) @(posedge clk_sys);
    chk("lines_chan", 16'(lines), 16'h0000);
    ser_irq <= '0;
    // sync codes 1 to 15 on channel 1: waits for its own event, 15 ignores every serial, alt and timer event
    wr(8'h21, 16'h00c0);
    wr(8'h24, 16'h0000);
    for (int c = 1; c < 16; c++) begin
      wr(8'h22, 16'h0000);
      wr(8'h23, 16'(c) << 12);
      dcci_mem_model_i.wlog.delete();
      wr(8'h00, 16'h0002);
      repeat (8) @(posedge clk_sys);
      chk("early", nw(), 16'h0000);
      bp = (c < 7) ? c + 6 : (c < 13) ? c - 6 : 0;
      @(posedge clk_sys);
      if (c < 14) begin
        evt <= dcci_evt_t'(13'h0001 << bp);
      end else if (c == 14) begin
        ext3_n <= 1'b0;
      end else begin
        evt <= '1;
      end
      @(posedge clk_sys);
      evt    <= '0;
      ext3_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
      chk("started", nw(), (c == 15) ? 16'h0000 : 16'h0001);
      wr(8'h00, 16'h0000);
    end
    // doubleword: two halves, one element
    wr(8'h30, 16'h0060);
    wr(8'h31, 16'h00e0);
    wr(8'h34, 16'h0105);
    dcci_mem_model_i.wlog.delete();
    wr(8'h00, 16'h0004);
    wait_idle(2);
    for (int j = 0; j < 2; j++) begin
      w = wl(j);
      chk("dw_addr", w[31:16], 16'h00e0 + 16'(j));
      chk("dw_data", w[15:0], 16'h5a60 + 16'(j));
    end
    chk("dw_writes", nw(), 16'h0002);
    // autobuffer mode 1 on channel 0: four-element buffer, half and full
    wr(8'h12, 16'h0003);
    wr(8'h14, 16'h7000);
    dcci_mem_model_i.wlog.delete();
    i0 = n_irq;
    wr(8'h00, 16'h0001);
    repeat (40) @(posedge clk_sys);
    wr(8'h00, 16'h0000);
    repeat (8) @(posedge clk_sys);
    chk("abu_irqs", 16'(n_irq - i0), 16'(nw() / 4 * 2 + ((nw() % 4) > 1)));
    // reinit keeps the channel running past block end
    wr(8'h44, 16'h8000);
    dcci_mem_model_i.wlog.delete();
    wr(8'h00, 16'h0008);
    repeat (30) @(posedge clk_sys);
    rd(8'h00);
    chk("reinit_on", rdata & 16'h0008, 16'h0008);
    chk("reinit_runs", 16'(nw() > 16'h0002), 16'h0001);
    wr(8'h00, 16'h0000);
    repeat (10) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
